// File: rtl/tcrss_pkg.sv
package tcrss_pkg;

    // On-chip signal sources offered to both timers
    typedef struct packed {
        logic fast_internal_oscillator;
        logic slow_internal_oscillator;
        logic medium_internal_oscillator_500k;
        logic medium_internal_oscillator_32k;
        logic secondary_oscillator;
        logic external_oscillator;
        logic reference_clock_output;
        logic numeric_oscillator_output;
        logic zero_cross_output;
        logic [3:0] logic_cell_output;
        logic [1:0] comparator_output;
        logic capture_compare_output;
        logic [5:0] pwm_output;
        logic [2:0] uart_receive_line;
        logic [2:0] uart_transmit_line;
    } tcrss_src_s;

    // Signals picked for one timer
    typedef struct packed {
        logic clock_tick;
        logic reset_signal;
    } tcrss_sel_s;

    typedef logic [3:0] tcrss_clk_code_t;
    typedef logic [4:0] tcrss_rst_code_t;

endpackage

// File: rtl/tcrss_regs.svh
`ifndef TCRSS_REGS_SVH
`define TCRSS_REGS_SVH

// Register indices; byte address is four times the index
`define TCRSS_IDX_T2_CLOCK 12'h320
`define TCRSS_IDX_T2_RESET 12'h321
`define TCRSS_IDX_T4_CLOCK 12'h32D
`define TCRSS_IDX_T4_RESET 12'h32E

// Field reset values
`define TCRSS_CLOCK_INIT 4'h0
`define TCRSS_RESET_INIT 5'h00

// Clock source codes
`define TCRSS_CS_PIN 4'h0
`define TCRSS_CS_FOSC4 4'h1
`define TCRSS_CS_FOSC 4'h2
`define TCRSS_CS_FAST 4'h3
`define TCRSS_CS_SLOW 4'h4
`define TCRSS_CS_MED500 4'h5
`define TCRSS_CS_MED32 4'h6
`define TCRSS_CS_SECOND 4'h7
`define TCRSS_CS_EXTERN 4'h8
`define TCRSS_CS_REFCLK 4'h9
`define TCRSS_CS_NCO 4'hA
`define TCRSS_CS_ZERO 4'hB
`define TCRSS_CS_CELL1 4'hC

// Reset source codes
`define TCRSS_RS_PIN 5'h00
`define TCRSS_RS_POST4 5'h02
`define TCRSS_RS_POST2 5'h01
`define TCRSS_RS_CAPTURE 5'h04
`define TCRSS_RS_PWM1 5'h05
`define TCRSS_RS_PWM6 5'h0A
`define TCRSS_RS_CMP1 5'h0B
`define TCRSS_RS_CMP2 5'h0C
`define TCRSS_RS_ZERO 5'h0D
`define TCRSS_RS_CELL1 5'h0E
`define TCRSS_RS_CELL4 5'h11
`define TCRSS_RS_UART1 5'h12
`define TCRSS_RS_UART6 5'h17
`define TCRSS_RS_RESV 5'h18

// Level triggered hardware limit modes
`define TCRSS_MODE_LVL_LOW 5'h16
`define TCRSS_MODE_LVL_HIGH 5'h17

// UART lines idle high; edge history starts there so reset makes no false edge
`define TCRSS_UART_IDLE 6'h3F

// Quarter rate divider terminal count
`define TCRSS_DIV_LAST 2'h3

`endif

// File: rtl/tcrss_source_mux.sv
`timescale 1ns/1ns
`include "tcrss_regs.svh"

module tcrss_source_mux #(
    parameter bit SECOND_TIMER = 1'b0 // Set for the second timer
) (
    input wire tcrss_pkg::tcrss_clk_code_t clock_code, // Clock select field
    input wire tcrss_pkg::tcrss_rst_code_t reset_code, // Reset select field
    input wire tcrss_pkg::tcrss_src_s sources, // Shared sources
    input wire logic [5:0] uart_edge, // Line edges rx1,tx1..rx3,tx3
    input wire logic quarter_tick, // System clock over four
    input wire logic own_pin, // Own remappable input pin
    input wire logic partner_postscaled, // Other timer postscaler
    output tcrss_pkg::tcrss_sel_s selection // Picked clock and reset
);

    logic [4:0] rst_off;

    // Clock source choice
    always_comb
    begin
        selection.clock_tick = 1'b0;
        case (clock_code)
            `TCRSS_CS_PIN: selection.clock_tick = own_pin;
            `TCRSS_CS_FOSC4: selection.clock_tick = quarter_tick;
            `TCRSS_CS_FOSC: selection.clock_tick = 1'b1;
            `TCRSS_CS_FAST: selection.clock_tick = sources.fast_internal_oscillator;
            `TCRSS_CS_SLOW: selection.clock_tick = sources.slow_internal_oscillator;
            `TCRSS_CS_MED500: selection.clock_tick = sources.medium_internal_oscillator_500k;
            `TCRSS_CS_MED32: selection.clock_tick = sources.medium_internal_oscillator_32k;
            `TCRSS_CS_SECOND: selection.clock_tick = sources.secondary_oscillator;
            `TCRSS_CS_EXTERN: selection.clock_tick = sources.external_oscillator;
            `TCRSS_CS_REFCLK: selection.clock_tick = sources.reference_clock_output;
            `TCRSS_CS_NCO: selection.clock_tick = sources.numeric_oscillator_output;
            `TCRSS_CS_ZERO: selection.clock_tick = sources.zero_cross_output;
            default:
                selection.clock_tick = sources.logic_cell_output[clock_code[1:0]];
        endcase

        // Reset source choice; reserved codes give a quiet low
        rst_off = 5'h00;
        selection.reset_signal = 1'b0;
        if (reset_code == `TCRSS_RS_PIN)
            selection.reset_signal = own_pin;
        else if (reset_code == `TCRSS_RS_POST4 && !SECOND_TIMER)
            selection.reset_signal = partner_postscaled;
        else if (reset_code == `TCRSS_RS_POST2 && SECOND_TIMER)
            selection.reset_signal = partner_postscaled;
        else if (reset_code == `TCRSS_RS_CAPTURE)
            selection.reset_signal = sources.capture_compare_output;
        else if (reset_code >= `TCRSS_RS_PWM1 && reset_code <= `TCRSS_RS_PWM6)
        begin
            rst_off = reset_code - `TCRSS_RS_PWM1;
            selection.reset_signal = sources.pwm_output[rst_off[2:0]];
        end
        else if (reset_code == `TCRSS_RS_CMP1)
            selection.reset_signal = sources.comparator_output[0];
        else if (reset_code == `TCRSS_RS_CMP2)
            selection.reset_signal = sources.comparator_output[1];
        else if (reset_code == `TCRSS_RS_ZERO)
            selection.reset_signal = sources.zero_cross_output;
        else if (reset_code >= `TCRSS_RS_CELL1 && reset_code <= `TCRSS_RS_CELL4)
        begin
            rst_off = reset_code - `TCRSS_RS_CELL1;
            selection.reset_signal = sources.logic_cell_output[rst_off[1:0]];
        end
        else if (reset_code >= `TCRSS_RS_UART1 && reset_code <= `TCRSS_RS_UART6)
        begin
            rst_off = reset_code - `TCRSS_RS_UART1;
            selection.reset_signal = uart_edge[rst_off[2:0]];
        end
    end

endmodule

// File: rtl/tcrss_top.sv
// Contract
// - The 4-bit clock field picks sixteen sources, 0 the pin, 1 system clock over four, 2 it whole.
// - Codes 3 to 15 pick fast, slow, medium 500k and 32k oscillators, then the rest in order.
// - Both timers share the clock map except code 0, which routes each timer's own pin.
// - The 5-bit reset field in bits 4:0 picks the external reset or trigger of the timer.
// - Reset codes 4 to 23 pick capture, six PWM, comparators, zero cross, cells, UART edges.
// - Reset code 0 is the own pin; first timer takes the partner postscaler at 2, second at 1.
// - The clock select registers sit at index 0x320 and 0x32D.
// - The reset select registers sit at index 0x321 and 0x32E.
// - In level hardware limit modes the reset level holds the timer until run and release.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ns
`include "tcrss_regs.svh"

module tcrss_top #(
    parameter int ADDR_W = 14 // APB byte address width
) (
    input wire logic pclk, // Bus clock, 10 MHz
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire tcrss_pkg::tcrss_src_s sources, // Shared on-chip sources
    input wire logic [1:0] own_pin, // Remappable pin per timer
    input wire logic [1:0] postscaled, // Postscaler output per timer
    input wire logic [1:0] run_bit, // Timer run bit per timer
    input wire logic [9:0] hlt_mode, // Hardware limit mode, 5 bits each
    output logic [1:0] clock_tick, // Selected clock per timer
    output logic [1:0] reset_signal, // Selected reset per timer
    output logic [1:0] counter_hold // Hold timer in reset
);

    localparam logic [ADDR_W-1:0] CLK_ADDR [2] = '{
        ADDR_W'({`TCRSS_IDX_T2_CLOCK, 2'b00}),
        ADDR_W'({`TCRSS_IDX_T4_CLOCK, 2'b00})
    };
    localparam logic [ADDR_W-1:0] RST_ADDR [2] = '{
        ADDR_W'({`TCRSS_IDX_T2_RESET, 2'b00}),
        ADDR_W'({`TCRSS_IDX_T4_RESET, 2'b00})
    };

    tcrss_pkg::tcrss_clk_code_t clk_q [2];
    tcrss_pkg::tcrss_rst_code_t rst_q [2];
    tcrss_pkg::tcrss_sel_s sel [2];
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic [31:0] read_mux;
    logic addr_hit;
    logic write_fire;
    logic [1:0] div_cnt;
    logic [1:0] next_div_cnt;
    logic quarter_tick;
    logic [5:0] uart_line;
    logic [5:0] uart_last;
    logic [5:0] next_uart_last;
    logic [5:0] uart_edge;

    // Address decode and read data for the four registers
    always_comb
    begin
        addr_hit = 1'b0;
        read_mux = 32'h0000_0000;
        for (int i = 0; i < 2; i++)
        begin
            if (paddr == CLK_ADDR[i])
            begin
                addr_hit = 1'b1;
                read_mux = {28'h000_0000, clk_q[i]};
            end
            if (paddr == RST_ADDR[i])
            begin
                addr_hit = 1'b1;
                read_mux = {27'h000_0000, rst_q[i]};
            end
        end
    end

    // APB answer, one wait state, ready for one cycle
    always_comb
    begin
        next_pready = psel && penable && !pready;
        next_pslverr = next_pready && !addr_hit;
        next_prdata = 32'h0000_0000;
        if (next_pready && !pwrite && addr_hit)
            next_prdata = read_mux;
    end

    assign write_fire = psel && penable && pready && pwrite && !pslverr;

    // APB answer registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end

    // System clock over four, one tick in four cycles
    always_comb
    begin
        next_div_cnt = div_cnt + 2'h1;
        quarter_tick = (div_cnt == `TCRSS_DIV_LAST);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_cnt <= 2'h0;
        else
            div_cnt <= next_div_cnt;
    end

    // Either polarity edge on each UART line
    assign uart_line = {
        sources.uart_transmit_line[2], sources.uart_receive_line[2],
        sources.uart_transmit_line[1], sources.uart_receive_line[1],
        sources.uart_transmit_line[0], sources.uart_receive_line[0]
    };

    always_comb
    begin
        next_uart_last = uart_line;
        uart_edge = uart_line ^ uart_last;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            uart_last <= `TCRSS_UART_IDLE;
        else
            uart_last <= next_uart_last;
    end

    // Per timer selection registers, source mux and outputs
    for (genvar t = 0; t < 2; t++)
    begin : g_timer
        tcrss_pkg::tcrss_clk_code_t next_clk;
        tcrss_pkg::tcrss_rst_code_t next_rst;
        logic [4:0] mode;
        logic next_hold;

        assign mode = hlt_mode[5*t +: 5];

        // Field writes; new codes act at once, so software
        // switches sources only with the timer off
        always_comb
        begin
            next_clk = clk_q[t];
            next_rst = rst_q[t];
            if (write_fire && paddr == CLK_ADDR[t])
                next_clk = pwdata[3:0];
            if (write_fire && paddr == RST_ADDR[t])
                next_rst = pwdata[4:0];
        end

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                clk_q[t] <= `TCRSS_CLOCK_INIT;
                rst_q[t] <= `TCRSS_RESET_INIT;
            end
            else
            begin
                clk_q[t] <= next_clk;
                rst_q[t] <= next_rst;
            end
        end

        tcrss_source_mux #(
            .SECOND_TIMER(t == 1)
        ) u_mux (
            .clock_code(clk_q[t]),
            .reset_code(rst_q[t]),
            .sources(sources),
            .uart_edge(uart_edge),
            .quarter_tick(quarter_tick),
            .own_pin(own_pin[t]),
            .partner_postscaled(postscaled[1-t]),
            .selection(sel[t])
        );

        // Level hardware limit hold: reset level or run bit clear
        always_comb
        begin
            next_hold = 1'b0;
            if (mode == `TCRSS_MODE_LVL_LOW)
                next_hold = !run_bit[t] || !sel[t].reset_signal;
            else if (mode == `TCRSS_MODE_LVL_HIGH)
                next_hold = !run_bit[t] || sel[t].reset_signal;
        end

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                clock_tick[t] <= 1'b0;
                reset_signal[t] <= 1'b0;
                counter_hold[t] <= 1'b0;
            end
            else
            begin
                clock_tick[t] <= sel[t].clock_tick;
                reset_signal[t] <= sel[t].reset_signal;
                counter_hold[t] <= next_hold;
            end
        end
    end

    // Checks on the selection behaviour
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_quarter_gap;
        !quarter_tick [*3] ##1 quarter_tick;
    endsequence

    chk_quarter_rate: assert property (
        quarter_tick |=> s_quarter_gap)
        else $error("quarter tick not one in four");

    chk_fosc_full: assert property (
        clk_q[0] == `TCRSS_CS_FOSC |=> clock_tick[0])
        else $error("undivided clock not passed");

    chk_slow_osc: assert property (
        clk_q[1] == `TCRSS_CS_SLOW |=>
        clock_tick[1] == $past(sources.slow_internal_oscillator))
        else $error("slow oscillator not routed");

    chk_own_pin: assert property (
        clk_q[1] == `TCRSS_CS_PIN |=> clock_tick[1] == $past(own_pin[1]))
        else $error("second timer pin not routed");

    chk_reset_store: assert property (
        write_fire && paddr == RST_ADDR[0] |=> rst_q[0] == $past(pwdata[4:0]))
        else $error("reset field not stored");

    chk_reserved_low: assert property (
        rst_q[0] >= `TCRSS_RS_RESV |=> !reset_signal[0])
        else $error("reserved reset code not quiet");

    chk_partner_post: assert property (
        rst_q[0] == `TCRSS_RS_POST4 |=> reset_signal[0] == $past(postscaled[1]))
        else $error("partner postscaler not routed");

    chk_post_reserved: assert property (
        rst_q[1] == `TCRSS_RS_POST4 |=> !reset_signal[1])
        else $error("reserved postscaler code not quiet");

    chk_clk_offset: assert property (
        pready && !pwrite && paddr == CLK_ADDR[1] |-> prdata == {28'h000_0000, clk_q[1]})
        else $error("clock register read wrong");

    chk_rst_offset: assert property (
        pready && !pwrite && paddr == RST_ADDR[1] |-> prdata == {27'h000_0000, rst_q[1]})
        else $error("reset register read wrong");

    chk_level_hold: assert property (
        hlt_mode[4:0] == `TCRSS_MODE_LVL_HIGH && !run_bit[0] |=> counter_hold[0])
        else $error("hold missing with run bit clear");

    chk_low_release: assert property (
        hlt_mode[4:0] == `TCRSS_MODE_LVL_LOW && run_bit[0] |=>
        counter_hold[0] == !reset_signal[0])
        else $error("low level hold does not follow reset");

    chk_mode_idle: assert property (
        hlt_mode[4:0] != `TCRSS_MODE_LVL_LOW && hlt_mode[4:0] != `TCRSS_MODE_LVL_HIGH |=>
        !counter_hold[0])
        else $error("hold raised outside level modes");

    chk_uart_either: assert property (
        rst_q[0] == `TCRSS_RS_UART1 |=> reset_signal[0] ==
        ($past(sources.uart_receive_line[0]) ^ $past(sources.uart_receive_line[0], 2)))
        else $error("receive line edge not routed");

    chk_cell_route: assert property (
        clk_q[0] == `TCRSS_CS_CELL1 |=>
        clock_tick[0] == $past(sources.logic_cell_output[0]))
        else $error("logic cell clock not routed");

    chk_clk_answer: assert property (
        psel && penable && !pready && paddr == CLK_ADDR[0] |=> pready && !pslverr)
        else $error("clock register access not answered");

    chk_ready_pulse: assert property (
        pready |=> !pready)
        else $error("ready longer than one cycle");

endmodule

// File: verification/tcrss_bench.sv
`timescale 1ns/1ns
`include "tcrss_regs.svh"

module tcrss_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [13:0] paddr = 14'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    tcrss_pkg::tcrss_src_s sources;
    logic [1:0] own_pin;
    logic [1:0] postscaled;
    logic [1:0] run_bit = 2'h0;
    logic [9:0] hlt_mode = 10'h000;
    logic [1:0] clock_tick;
    logic [1:0] reset_signal;
    logic [1:0] counter_hold;
    logic slow = 1'b0;
    logic chk_en = 1'b0;
    int miscompares = 0;
    int checks_done = 0;
    logic [3:0] m_clk [2] = '{4'h0, 4'h0};
    logic [4:0] m_rst [2] = '{5'h00, 5'h00};
    logic [5:0] prev_line = 6'h00;
    logic [5:0] ln;
    logic e_clk [2];
    logic e_rst [2];
    logic e_hold [2];
    logic e_quart [2];
    int n1 [2] = '{0, 0};
    int h1 [2] = '{0, 0};

    always #50 pclk = ~pclk;

    tcrss_source_model partner (.pclk(pclk), .slow(slow), .sources(sources),
        .own_pin(own_pin), .postscaled(postscaled));

    tcrss_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sources(sources), .own_pin(own_pin),
        .postscaled(postscaled), .run_bit(run_bit), .hlt_mode(hlt_mode),
        .clock_tick(clock_tick), .reset_signal(reset_signal),
        .counter_hold(counter_hold));

    // Clock source table, bit index equals the code
    function automatic logic f_clk(input logic [3:0] c, input int t,
        input tcrss_pkg::tcrss_src_s s, input logic [1:0] pin);
        logic [15:0] v;
        v = {s.logic_cell_output, s.zero_cross_output, s.numeric_oscillator_output,
            s.reference_clock_output, s.external_oscillator, s.secondary_oscillator,
            s.medium_internal_oscillator_32k, s.medium_internal_oscillator_500k,
            s.slow_internal_oscillator, s.fast_internal_oscillator, 1'b1, 1'b0, pin[t]};
        return v[c];
    endfunction

    // Reset source table, reserved codes give zero
    function automatic logic f_rst(input logic [4:0] c, input int t,
        input tcrss_pkg::tcrss_src_s s, input logic [5:0] e, input logic [1:0] pin,
        input logic [1:0] post);
        logic [23:0] v;
        v = {e, s.logic_cell_output, s.zero_cross_output, s.comparator_output,
            s.pwm_output, s.capture_compare_output, 1'b0, t == 0 && post[1],
            t == 1 && post[0], pin[t]};
        return (c < 5'h18) ? v[c] : 1'b0;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (miscompares == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Model of what each timer should see, one cycle behind the sources
    assign ln = {sources.uart_transmit_line[2], sources.uart_receive_line[2],
        sources.uart_transmit_line[1], sources.uart_receive_line[1],
        sources.uart_transmit_line[0], sources.uart_receive_line[0]};
    always @(posedge pclk)
    begin
        for (int t = 0; t < 2; t++)
        begin
            logic r;
            logic [4:0] m;
            r = f_rst(m_rst[t], t, sources, ln ^ prev_line, own_pin, postscaled);
            m = hlt_mode[t*5 +: 5];
            e_clk[t] <= f_clk(m_clk[t], t, sources, own_pin);
            e_quart[t] <= (m_clk[t] == 4'h1);
            e_rst[t] <= r;
            e_hold[t] <= (m == `TCRSS_MODE_LVL_LOW) ? (!run_bit[t] || !r) :
                (m == `TCRSS_MODE_LVL_HIGH) ? (!run_bit[t] || r) : 1'b0;
        end
        prev_line <= presetn ? ln : `TCRSS_UART_IDLE;
    end

    // Compare at the falling edge, once outputs have settled
    always @(negedge pclk)
        if (chk_en)
            for (int t = 0; t < 2; t++)
            begin
                if (e_quart[t])
                begin
                    n1[t]++;
                    h1[t] += int'(clock_tick[t]);
                    if (n1[t] == 32)
                    begin
                        check(h1[t], 8);
                        n1[t] = 0;
                        h1[t] = 0;
                    end
                end
                else
                begin
                    n1[t] = 0;
                    h1[t] = 0;
                    check(clock_tick[t], e_clk[t]);
                end
                check(reset_signal[t], e_rst[t]);
                check(counter_hold[t], e_hold[t]);
            end

    // One APB transfer, started right after a rising edge
    task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        if (wr)
            case (idx)
                `TCRSS_IDX_T2_CLOCK: m_clk[0] <= wd[3:0];
                `TCRSS_IDX_T4_CLOCK: m_clk[1] <= wd[3:0];
                `TCRSS_IDX_T2_RESET: m_rst[0] <= wd[4:0];
                `TCRSS_IDX_T4_RESET: m_rst[1] <= wd[4:0];
                default: ;
            endcase
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Select one source with the timer off, read it back, then let it run
    task automatic pick(input int t, input bit rs, input int c);
        logic [31:0] w;
        logic [31:0] rd;
        logic err;
        logic [11:0] idx;
        idx = rs ? (t ? `TCRSS_IDX_T4_RESET : `TCRSS_IDX_T2_RESET) :
            (t ? `TCRSS_IDX_T4_CLOCK : `TCRSS_IDX_T2_CLOCK);
        w = ($urandom & 32'hFFFF_FFE0) | 32'(c);
        run_bit <= 2'h0;
        apb(1'b1, idx, w, rd, err);
        apb(1'b0, idx, 32'h0000_0000, rd, err);
        check(rd, w & (rs ? 32'h0000_001F : 32'h0000_000F));
        check(err, 1'b0);
        hlt_mode[t*5 +: 5] <= (c % 3 == 0) ? `TCRSS_MODE_LVL_LOW :
            (c % 3 == 1) ? `TCRSS_MODE_LVL_HIGH : 5'($urandom);
        slow <= c[0];
        repeat (5)
        begin
            run_bit <= 2'($urandom);
            repeat (8) @(posedge pclk);
        end
    endtask

    initial
    begin
        logic [31:0] rd;
        logic err;
        void'($urandom(17823));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk_en <= 1'b1;
        // Reset values of all four registers
        foreach (m_clk[t])
        begin
            apb(1'b0, t ? `TCRSS_IDX_T4_CLOCK : `TCRSS_IDX_T2_CLOCK, 0, rd, err);
            check(rd, 32'h0000_0000);
            apb(1'b0, t ? `TCRSS_IDX_T4_RESET : `TCRSS_IDX_T2_RESET, 0, rd, err);
            check(rd, 32'h0000_0000);
        end
        // Unmapped index refuses and reads zero
        apb(1'b1, 12'h322, 32'hFFFF_FFFF, rd, err);
        check(err, 1'b1);
        apb(1'b0, 12'h322, 32'h0000_0000, rd, err);
        check({err, rd}, {1'b1, 32'h0000_0000});
        // Every clock code, then every reset code, on both timers
        for (int t = 0; t < 2; t++)
            for (int c = 0; c < 16; c++)
                pick(t, 1'b0, c);
        for (int t = 0; t < 2; t++)
            for (int c = 0; c < 32; c++)
                pick(t, 1'b1, c);
        end_sim();
    end

    // Watchdog against a hung transfer
    initial
    begin
        repeat (30000) @(posedge pclk);
        miscompares++;
        end_sim();
    end
endmodule

// File: verification/tcrss_source_model.sv
`timescale 1ns/1ns

module tcrss_source_model (
    input wire logic pclk, // Bus clock
    input wire logic slow, // Hold each level four cycles
    output tcrss_pkg::tcrss_src_s sources, // On-chip sources
    output logic [1:0] own_pin, // Pin per timer
    output logic [1:0] postscaled // Postscaler output per timer
);
    logic [1:0] gap;

    // Quiet levels at time zero
    initial
    begin
        gap = 2'h0;
        sources = '0;
        own_pin = 2'h0;
        postscaled = 2'h0;
    end

    // Fresh random levels after each edge, or every fourth when slow
    always @(posedge pclk)
    begin
        gap <= gap + 2'h1;
        if (!slow || gap == 2'h3)
        begin
            sources <= tcrss_pkg::tcrss_src_s'(28'($urandom));
            own_pin <= 2'($urandom);
            postscaled <= 2'($urandom);
        end
    end
endmodule
